// *** hdl/tssc_pkg.sv ***
// Shared constants and types of the temperature sensor serial control block.
package tssc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 20;
  localparam int CONV_TIME_13_US = 400;
  localparam int CONV_CYCLES_13  = (CONV_TIME_13_US * 1000) / CLK_PERIOD_NS;

  // ****************************************************************
  // Word, command and register layout
  // ****************************************************************
  localparam int WORD_BITS    = 16;
  localparam int BYTE_BITS    = 8;
  localparam int CMD_RW_BIT   = 7;
  localparam logic [2:0] ADDR_CTRL  = 3'h1;
  localparam logic [2:0] ADDR_THIGH = 3'h2;
  localparam logic [2:0] ADDR_TLOW  = 3'h3;
  localparam logic [2:0] ADDR_ID    = 3'h7;

  localparam int CTRL_SHDN_BIT    = 15;
  localparam int CTRL_ONESHOT_BIT = 14;
  localparam int CTRL_ALMCLR_BIT  = 13;
  localparam int CTRL_RES_LSB     = 4;
  localparam int CTRL_READY_BIT   = 2;
  localparam int CTRL_ALARM_BIT   = 1;

  // ****************************************************************
  // Reset values and fixed words
  // ****************************************************************
  localparam logic [7:0]  CMD_RST        = 8'h00;
  localparam logic [1:0]  RES_RST        = 2'h0;
  localparam logic [15:0] THIGH_RST      = 16'h4000;
  localparam logic [15:0] TLOW_RST       = 16'h3c00;
  localparam logic [15:0] ID_VALUE       = 16'h0a5c;  // Arbitrary identification value.
  localparam logic [15:0] TEMP_BUSY_WORD = 16'h8000;
  localparam logic [4:0]  BITS_PER_WORD  = 5'h10;
  localparam logic [4:0]  BITS_PER_BYTE  = 5'h08;

  typedef enum logic [2:0] {ST_IDLE, ST_TEMP, ST_CMD, ST_RDATA, ST_WDATA} tssc_state_t;

endpackage : tssc_pkg

// *** hdl/tssc_conv_if.sv ***
// Carrier between the serial front end and the conversion engine.
`timescale 1ns/1ps
`default_nettype none
interface tssc_conv_if;
  logic        shutdown;
  logic [1:0]  res;
  logic        oneshot;
  logic        alarm_clr;
  logic [15:0] thigh;
  logic [15:0] tlow;
  logic [15:0] temp_word;
  logic        ready;
  logic        alarm;
  modport ctl (output shutdown, res, oneshot, alarm_clr, thigh, tlow,
               input  temp_word, ready, alarm);
  modport eng (input  shutdown, res, oneshot, alarm_clr, thigh, tlow,
               output temp_word, ready, alarm);
endinterface : tssc_conv_if
`default_nettype wire

// *** hdl/tssc_sync.sv ***
// Two-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module tssc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : tssc_sync
`default_nettype wire

// *** hdl/tssc_conv.sv ***
// Conversion engine: timing, result formatting, one-shot state and alarm comparator.
`timescale 1ns/1ps
`default_nettype none
module tssc_conv
  import tssc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_13
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [15:0] meas_temp_in,
  tssc_conv_if.eng         cif
);
  logic        running_q;
  logic        oneshot_q;
  logic [31:0] cnt_q;
  logic [1:0]  res_q;
  logic [15:0] temp_q;
  logic        ready_q;
  logic        alarm_q;
  logic        toggle_q;
  logic        done;
  logic        start_os;
  logic        start;
  logic [15:0] fmt;
  logic [15:0] cmp;

  function automatic logic [15:0] format_temp(input logic [15:0] raw, input logic [1:0] res,
                                              input logic tog);
    unique case (res)
      2'h0: format_temp = {raw[15:3], 2'h0, tog};
      2'h1: format_temp = {raw[15:2], 1'h0, tog};
      2'h2: format_temp = {raw[15:1], tog};
      2'h3: format_temp = raw;
    endcase
  endfunction

  assign done     = running_q && (cnt_q == ((32'(CONV_CYCLES) << res_q) - 32'h1));
  assign start_os = !running_q && cif.shutdown && cif.oneshot;
  assign start    = !running_q && (!cif.shutdown || cif.oneshot);
  assign fmt      = format_temp(meas_temp_in, res_q, ~toggle_q);
  assign cmp      = (res_q == 2'h3) ? fmt : {fmt[15:1], 1'h0};
  assign cif.temp_word = oneshot_q ? TEMP_BUSY_WORD : temp_q;
  assign cif.ready     = ready_q;
  assign cif.alarm     = alarm_q;

  // ****************************************************************
  // Conversion timing
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      running_q <= 1'h0;
      oneshot_q <= 1'h0;
      cnt_q     <= 32'h0;
      res_q     <= RES_RST;
    end else if (start) begin
      running_q <= 1'h1;
      oneshot_q <= cif.shutdown;
      cnt_q     <= 32'h0;
      res_q     <= cif.res;
    end else if (done) begin
      running_q <= 1'h0;
      oneshot_q <= 1'h0;
    end else begin
      cnt_q     <= cnt_q + 32'h1;
    end
  end

  // ****************************************************************
  // Result and ready flag
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      temp_q   <= 16'h0000;
      ready_q  <= 1'h0;
      toggle_q <= 1'h0;
    end else if (done) begin
      temp_q   <= fmt;
      ready_q  <= 1'h1;
      toggle_q <= ~toggle_q;
    end else if (start_os) begin
      ready_q  <= 1'h0;
    end
  end

  // ****************************************************************
  // Alarm comparator with hysteresis; a completion past either limit wins over a clear.
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      alarm_q <= 1'h0;
    end else if (done && ($signed(cmp) > $signed(cif.thigh))) begin
      alarm_q <= 1'h1;
    end else if (done && ($signed(cmp) < $signed(cif.tlow))) begin
      alarm_q <= 1'h0;
    end else if (cif.alarm_clr) begin
      alarm_q <= 1'h0;
    end
  end

  chk_busy_word: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    oneshot_q |-> (cif.temp_word == TEMP_BUSY_WORD) && !cif.ready)
    else $error("One-shot state does not show the busy word.");
  chk_oneshot_start: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    start_os |=> oneshot_q && running_q && (cnt_q == 32'h0))
    else $error("One-shot request did not start a conversion.");
  chk_alarm_set: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (done && ($signed(cmp) > $signed(cif.thigh))) |=> alarm_q)
    else $error("Alarm missing above the upper limit.");
  chk_alarm_hyst: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (done && ($signed(cmp) < $signed(cif.tlow)) && !($signed(cmp) > $signed(cif.thigh)))
    |=> !alarm_q)
    else $error("Alarm held below the lower limit.");
  chk_alarm_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (cif.alarm_clr && !done) |=> !alarm_q)
    else $error("Alarm reset did not clear the alarm.");
  chk_shdn_finish: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (running_q && !done) |=> running_q && (cnt_q == $past(cnt_q) + 32'h1))
    else $error("Conversion cut short.");
  chk_ready_done: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    done |=> ready_q && !oneshot_q && (temp_q == $past(fmt)))
    else $error("Completion did not publish the result.");
endmodule : tssc_conv
`default_nettype wire

// *** hdl/tssc_top.sv ***
// Top of the temperature sensor serial control block: serial protocol and registers.
//
// Functional notes
// - Registers take their defaults at reset; apart from temperature, ready flag and alarm they change only by host writes.
// - One-shot write while in shutdown starts exactly one conversion and compare.
// - During one-shot, ready flag reads zero and temperature reads 8000h.
// - During one-shot every register except temperature and the control ready flag keeps its contents.
// - One-shot completion sets ready flag and loads the measured temperature.
// - Alarm asserts when temperature is strictly above the upper limit.
// - Asserted alarm releases when temperature falls below the lower limit.
// - Alarm reset bit clears alarm; it returns after next conversion if still hot.
// - Shutdown or one-shot start never changes the alarm output.
// - Transaction starts on chip select falling; host drives select and clock.
// - First 16 serial clocks shift the temperature word out.
// - Chip select rising during temperature read ends it immediately.
// - After temperature read, data line is input for a command byte.
// - Written data is latched in whole bytes after each eighth bit.
// - Chip select rising before eighth command falling edge keeps command unchanged.
// - Chip select rising between bits 8 and 16 stores only the upper byte.
// - Command and data pairs may repeat within one chip select assertion.
// - Temperature is two's complement, 13 to 16 bits by resolution.
// - At 13 bits, sign on top, toggle in D0, D1 and D2 zero.
// - Command: read flag bit 7, zeros 6..3, register select in bits 2..0.
// - Invalid addresses read zero and writes to them change nothing.
// - Temperature read never interrupts conversion; returns last completed result, or 8000h during one-shot.
// - Shutdown takes effect only after the running conversion completes.
`timescale 1ns/1ps
`default_nettype none
module tssc_top
  import tssc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_13
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        cs_b_in,
  input  wire logic        serial_shift_clock_in,
  input  wire logic        sio_in,
  input  wire logic [15:0] meas_temp_in,
  output var  logic        sio_out,
  output var  logic        sio_oe_out,
  output var  logic        over_limit_alarm_b_out
);

  if (CONV_CYCLES < 2) begin : g_bad_cycles
    $error("CONV_CYCLES must be at least 2.");
  end

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  logic [2:0] pins_s;
  logic       cs_b_s;
  logic       sclk_s;
  logic       sio_s;
  logic       cs_b_d;
  logic       sclk_d;
  logic       sclk_rise;
  logic       sclk_fall;

  tssc_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .clk_in   (ref_clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({cs_b_in, serial_shift_clock_in, sio_in}),
    .q_out    (pins_s)
  );

  assign cs_b_s    = pins_s[2];
  assign sclk_s    = pins_s[1];
  assign sio_s     = pins_s[0];
  assign sclk_rise = !cs_b_s && sclk_s && !sclk_d;
  assign sclk_fall = !cs_b_s && !sclk_s && sclk_d;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cs_b_d <= 1'h1;
      sclk_d <= 1'h0;
    end else begin
      cs_b_d <= cs_b_s;
      sclk_d <= sclk_s;
    end
  end

  // ****************************************************************
  // Registers and conversion engine
  // ****************************************************************
  logic        shdn_q;
  logic [1:0]  res_q;
  logic [15:0] thigh_q;
  logic [15:0] tlow_q;
  logic        oneshot_q;
  logic        alarm_clr_q;
  tssc_conv_if cif ();

  assign cif.shutdown  = shdn_q;
  assign cif.res       = res_q;
  assign cif.oneshot   = oneshot_q;
  assign cif.alarm_clr = alarm_clr_q;
  assign cif.thigh     = thigh_q;
  assign cif.tlow      = tlow_q;

  tssc_conv #(.CONV_CYCLES(CONV_CYCLES)) u_conv (
    .ref_clk_in   (ref_clk_in),
    .rst_b_in     (rst_b_in),
    .meas_temp_in (meas_temp_in),
    .cif          (cif.eng)
  );

  function automatic logic cmd_valid(input logic [7:0] cmd);
    cmd_valid = (cmd[6:3] == 4'h0) &&
                ((cmd[2:0] == ADDR_CTRL) || (cmd[2:0] == ADDR_THIGH) ||
                 (cmd[2:0] == ADDR_TLOW) || (cmd[2:0] == ADDR_ID));
  endfunction

  function automatic logic [15:0] reg_read(input logic [7:0] cmd, input logic shdn,
                                           input logic [1:0] res, input logic rdy,
                                           input logic alm, input logic [15:0] hi,
                                           input logic [15:0] lo);
    logic [15:0] ctrl;
    ctrl                 = 16'h0000;
    ctrl[CTRL_SHDN_BIT]  = shdn;
    ctrl[CTRL_RES_LSB+:2] = res;
    ctrl[CTRL_READY_BIT] = rdy;
    ctrl[CTRL_ALARM_BIT] = alm;
    reg_read = 16'h0000;
    if (cmd_valid(cmd)) begin
      unique case (cmd[2:0])
        ADDR_CTRL:  reg_read = ctrl;
        ADDR_THIGH: reg_read = hi;
        ADDR_TLOW:  reg_read = lo;
        default:    reg_read = ID_VALUE;
      endcase
    end
  endfunction

  // ****************************************************************
  // Serial protocol
  // ****************************************************************
  tssc_state_t state_q;
  logic [4:0]  cnt_q;
  logic [15:0] shift_q;
  logic [7:0]  cmd_sh_q;
  logic [7:0]  cmd_q;
  logic        wr_hi;
  logic        wr_lo;
  logic [7:0]  wr_byte;
  logic        cmd_latch;
  logic [15:0] rd_word;

  assign rd_word   = reg_read(cmd_sh_q, shdn_q, res_q, cif.ready, cif.alarm,
                              thigh_q, tlow_q);
  assign wr_byte   = {shift_q[6:0], sio_s};
  assign wr_hi     = (state_q == ST_WDATA) && sclk_rise &&
                     (cnt_q == BITS_PER_BYTE - 5'h1) && cmd_valid(cmd_q);
  assign wr_lo     = (state_q == ST_WDATA) && sclk_rise &&
                     (cnt_q == BITS_PER_WORD - 5'h1) && cmd_valid(cmd_q);
  assign cmd_latch = (state_q == ST_CMD) && sclk_fall && (cnt_q == BITS_PER_BYTE);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || cs_b_s) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 5'h00;
      sio_oe_out <= 1'h0;
      sio_out    <= 1'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cs_b_d) begin
            state_q    <= ST_TEMP;
            shift_q    <= cif.temp_word;
            sio_out    <= cif.temp_word[WORD_BITS-1];
            sio_oe_out <= 1'h1;
            cnt_q      <= 5'h00;
          end
        end
        ST_TEMP, ST_RDATA: begin
          if (sclk_rise) begin
            cnt_q <= cnt_q + 5'h01;
          end else if (sclk_fall && (cnt_q == BITS_PER_WORD)) begin
            state_q    <= ST_CMD;
            sio_oe_out <= 1'h0;
            cnt_q      <= 5'h00;
          end else if (sclk_fall && (cnt_q != 5'h00)) begin
            shift_q <= {shift_q[14:0], 1'h0};
            sio_out <= shift_q[14];
          end
        end
        ST_CMD: begin
          if (sclk_rise) begin
            cmd_sh_q <= {cmd_sh_q[6:0], sio_s};
            cnt_q    <= cnt_q + 5'h01;
          end else if (cmd_latch) begin
            cnt_q <= 5'h00;
            if (cmd_sh_q[CMD_RW_BIT]) begin
              state_q    <= ST_RDATA;
              shift_q    <= rd_word;
              sio_out    <= rd_word[WORD_BITS-1];
              sio_oe_out <= 1'h1;
            end else begin
              state_q <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (sclk_rise) begin
            shift_q <= {shift_q[14:0], sio_s};
            cnt_q   <= cnt_q + 5'h01;
            if (cnt_q == BITS_PER_WORD - 5'h1) begin
              state_q <= ST_CMD;
              cnt_q   <= 5'h00;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      cmd_q <= CMD_RST;
    end else if (cmd_latch) begin
      cmd_q <= cmd_sh_q;
    end
  end

  // ****************************************************************
  // Register writes, byte by byte
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      shdn_q      <= 1'h0;
      res_q       <= RES_RST;
      thigh_q     <= THIGH_RST;
      tlow_q      <= TLOW_RST;
      oneshot_q   <= 1'h0;
      alarm_clr_q <= 1'h0;
    end else begin
      oneshot_q   <= 1'h0;
      alarm_clr_q <= 1'h0;
      if (wr_hi) begin
        unique case (cmd_q[2:0])
          ADDR_CTRL: begin
            shdn_q      <= wr_byte[CTRL_SHDN_BIT-BYTE_BITS];
            oneshot_q   <= wr_byte[CTRL_ONESHOT_BIT-BYTE_BITS];
            alarm_clr_q <= wr_byte[CTRL_ALMCLR_BIT-BYTE_BITS];
          end
          ADDR_THIGH: thigh_q[15:8] <= wr_byte;
          ADDR_TLOW:  tlow_q[15:8]  <= wr_byte;
          default:    ;
        endcase
      end
      if (wr_lo) begin
        unique case (cmd_q[2:0])
          ADDR_CTRL:  res_q        <= wr_byte[CTRL_RES_LSB+:2];
          ADDR_THIGH: thigh_q[7:0] <= wr_byte;
          ADDR_TLOW:  tlow_q[7:0]  <= wr_byte;
          default:    ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Alarm pin
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      over_limit_alarm_b_out <= 1'h1;
    end else begin
      over_limit_alarm_b_out <= ~cif.alarm;
    end
  end

  chk_cs_abort: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    cs_b_s |=> !sio_oe_out && (state_q == ST_IDLE))
    else $error("Data line still driven after chip select rose.");
  chk_cmd_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !cmd_latch |=> $stable(cmd_q))
    else $error("Command byte changed without a full byte.");
  chk_temp_turn: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ((state_q == ST_TEMP) && sclk_fall && (cnt_q == BITS_PER_WORD))
    |=> (state_q == ST_CMD) && !sio_oe_out)
    else $error("Data line not released after the temperature word.");
  chk_invalid_write: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ((state_q == ST_WDATA) && !cmd_valid(cmd_q)) |=> $stable(thigh_q) && $stable(tlow_q)
    && $stable(shdn_q) && $stable(res_q))
    else $error("Invalid address modified a register.");
  chk_alarm_pin: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ##1 (over_limit_alarm_b_out == !$past(cif.alarm)))
    else $error("Alarm pin does not follow the alarm state.");
  chk_temp_start: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    ((state_q == ST_IDLE) && !cs_b_s && cs_b_d) |=> sio_oe_out && (state_q == ST_TEMP))
    else $error("Chip select fall did not start the temperature read.");

endmodule : tssc_top
`default_nettype wire

// *** bench/tssc_host.sv ***
// Behavioural host serial master that drives chip select, serial clock and data.
`timescale 1ns/1ps
`default_nettype none
module tssc_host (
  input  wire logic ref_clk_in,
  input  wire logic line_in,
  output var  logic cs_b_out,
  output var  logic sclk_out,
  output var  logic drv_out,
  output var  logic drv_oe_out
);
  initial begin
    cs_b_out   = 1'b1;
    sclk_out   = 1'b0;
    drv_out    = 1'b0;
    drv_oe_out = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // One 160 ns serial clock; the line is sampled late in the high phase, where it is settled.
  task automatic bit_x(input logic oe, input logic d, output logic q);
    drv_oe_out = oe;
    drv_out    = d;
    wait_n(4);
    sclk_out = 1'b1;
    wait_n(3);
    q = line_in;
    wait_n(1);
    sclk_out = 1'b0;
  endtask
  task automatic start_frame(output logic [15:0] temp);
    logic q;
    cs_b_out = 1'b0;
    wait_n(8);
    for (int i = 0; i < 16; i++) begin
      bit_x(1'b0, 1'b0, q);
      temp = {temp[14:0], q};
    end
  endtask
  task automatic access(input logic [7:0] cmd, input logic [15:0] wd, input int n,
                        output logic [15:0] rd);
    logic q;
    rd = 16'h0000;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, cmd[i], q);
    end
    for (int i = 0; i < n; i++) begin
      bit_x(~cmd[7], wd[15-i], q);
      rd = {rd[14:0], q};
    end
    drv_oe_out = 1'b0;
  endtask
  // Starts a temperature read and raises chip select after n bits.
  task automatic cut_frame(input int n);
    logic q;
    cs_b_out = 1'b0;
    wait_n(8);
    for (int i = 0; i < n; i++) begin
      bit_x(1'b0, 1'b0, q);
    end
    wait_n(2);
    cs_b_out = 1'b1;
    wait_n(5);
  endtask
  task automatic end_frame;
    wait_n(4);
    cs_b_out = 1'b1;
    wait_n(20);
  endtask
endmodule  // tssc_host
`default_nettype wire

// *** bench/temp_sensor_serial_control_tb.sv ***
// Self-checking testbench of the temperature sensor serial control block.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_serial_control_tb;
  import tssc_pkg::*;
  localparam int CONV = 200;
  logic        ref_clk;
  logic        rst_b;
  logic        cs_b, sclk, h_d, h_oe, dut_d, dut_oe, alarm_b, line;
  logic        idle_q;
  logic [15:0] meas;
  logic [15:0] t, r;
  int          err_total = 0;
  int          n_tests   = 0;
  always #10 ref_clk = ~ref_clk;
  // An undriven line toggles every clock; the host samples every 8 clocks, so within a frame it reads one fixed value.
  always @(posedge ref_clk) idle_q <= ~idle_q;
  assign line = dut_oe ? dut_d : (h_oe ? h_d : idle_q);
  tssc_top #(.CONV_CYCLES(CONV)) i_dut (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
    .cs_b_in(cs_b), .serial_shift_clock_in(sclk), .sio_in(line), .meas_temp_in(meas),
    .sio_out(dut_d), .sio_oe_out(dut_oe), .over_limit_alarm_b_out(alarm_b));
  tssc_host i_host (.ref_clk_in(ref_clk), .line_in(line), .cs_b_out(cs_b),
    .sclk_out(sclk), .drv_out(h_d), .drv_oe_out(h_oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input int n);
    i_host.start_frame(t);
    i_host.access({5'h00, a}, d, n, r);
    i_host.end_frame();
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    i_host.start_frame(t);
    i_host.access({5'h10, a}, 16'h0000, 16, d);
    i_host.end_frame();
  endtask
  task automatic t_reset_seq;
    wr(ADDR_CTRL, 16'h8000, 16);
    i_host.wait_n(2 * CONV);
    wr(ADDR_CTRL, 16'h0000, 16);
    i_host.wait_n(2 * CONV);
  endtask
  task automatic t_defaults;
    i_host.start_frame(t);
    i_host.access(8'h82, 16'h0000, 16, r);
    check(r, THIGH_RST);
    i_host.access(8'h83, 16'h0000, 16, r);
    check(r, TLOW_RST);
    i_host.access(8'h87, 16'h0000, 16, r);
    check(r, ID_VALUE);
    i_host.access(8'h84, 16'h0000, 16, r);
    check(r, 16'h0000);
    i_host.access(8'hca, 16'h0000, 16, r);
    check(r, 16'h0000);
    i_host.access(8'h04, 16'hffff, 16, r);
    i_host.access(8'h82, 16'h0000, 16, r);
    check(r, THIGH_RST);
    i_host.end_frame();
  endtask
  task automatic t_format;
    logic [15:0] keep;
    meas = 16'h5787;
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, 16'(s << CTRL_RES_LSB), 16);
      i_host.wait_n((CONV << s) * 2 + 20);
      i_host.start_frame(t);
      i_host.end_frame();
      keep = (s == 3) ? 16'hffff : 16'hfffe;
      check(t & keep, meas & ~(16'h0007 >> s));
    end
    wr(ADDR_CTRL, 16'h0000, 16);
  endtask
  task automatic t_alarm;
    meas = 16'h4100;
    i_host.wait_n(500);
    check({15'h0000, alarm_b}, 16'h0000);
    wr(ADDR_CTRL, 16'h8000, 16);
    i_host.wait_n(500);
    check({15'h0000, alarm_b}, 16'h0000);
    wr(ADDR_CTRL, 16'ha000, 16);
    i_host.wait_n(10);
    check({15'h0000, alarm_b}, 16'h0001);
    wr(ADDR_CTRL, 16'hc000, 16);
    i_host.start_frame(t);
    i_host.end_frame();
    check(t, TEMP_BUSY_WORD);
    i_host.wait_n(500);
    check({15'h0000, alarm_b}, 16'h0000);
    i_host.start_frame(t);
    i_host.access(8'h81, 16'h0000, 16, r);
    i_host.end_frame();
    check(t & 16'hfffe, 16'h4100);
    check(r, 16'h8006);
    wr(ADDR_CTRL, 16'h0000, 16);
    meas = 16'h3e00;
    i_host.wait_n(500);
    check({15'h0000, alarm_b}, 16'h0000);
    meas = 16'h3b00;
    i_host.wait_n(500);
    check({15'h0000, alarm_b}, 16'h0001);
  endtask
  task automatic t_partial;
    i_host.cut_frame(5);
    check({15'h0000, dut_oe}, 16'h0000);
    i_host.wait_n(20);
    rd(ADDR_TLOW, r);
    check(r, TLOW_RST);
    wr(ADDR_THIGH, 16'h3355, 16);
    wr(ADDR_THIGH, 16'h12ff, 12);
    rd(ADDR_THIGH, r);
    check(r, 16'h1255);
    wr(ADDR_THIGH, 16'hab00, 7);
    rd(ADDR_THIGH, r);
    check(r, 16'h1255);
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  initial begin
    ref_clk = 1'b0;
    rst_b   = 1'b0;
    idle_q  = 1'b0;
    meas    = 16'h0000;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    i_host.wait_n(5);
    t_reset_seq();
    t_defaults();
    t_format();
    t_alarm();
    t_partial();
    conclude();
  end
endmodule  // temp_sensor_serial_control_tb
`default_nettype wire
